// ===== src/temp_conversion_alarm_core.sv
// What this block does
// RULE_01 - Powers up idle, no conversion without trigger
// RULE_02 - Convert command code starts one conversion
// RULE_03 - Pin one function 11: rising edge converts
// RULE_04 - Master holds bus idle, strong pullup
// RULE_05 - Finished result queued, then back to standby
// RULE_06 - Result queue holds thirty-two results
// RULE_07 - Results are signed 16-bit, 0.005 C steps
// RULE_08 - Each result compared against both thresholds
// RULE_09 - Threshold bytes at 0x10 to 0x13
// RULE_10 - Below low / above high set status bits
// RULE_11 - Enabled alarm condition sets alarm flag
// RULE_12 - Pin zero function 3 drives interrupt low
// RULE_13 - Status read clears bits, flag and pin
// RULE_14 - In-range result never clears alarm flag
// RULE_15 - Thresholds reset to 0x7fff and 0x8000
// RULE_16 - Only flagged devices join alarm search
// RULE_17 - Master rereads status, reconverts after change
// RULE_18 - Pin levels readable as location bits
// RULE_19 - Pin function codes select input/output/special
// RULE_20 - Trigger during conversion is ignored
`timescale 1ns/1ps
`default_nettype none
module temp_conversion_alarm_core
  import temp_alarm_pkg::*;
#(
  parameter int RESULT_W = 16,
  parameter int QUEUE_DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic funcCmdValid,
  input wire logic [7:0] funcCmdCode,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic sensorStart,
  input wire logic sensorDone,
  input wire logic [RESULT_W-1:0] sensorResult,
  output logic convBusy,
  output logic alarmSearchJoin,
  input wire logic [2:0] pinIn,
  output logic [2:0] pinOut,
  output logic [2:0] pinOe,
  output logic [2:0] pinPulldown
);

  if (RESULT_W != 16) begin : g_width_check
    $error("result width must be 16 to match the byte-wide thresholds");
  end

  // The count register is one byte wide
  if (QUEUE_DEPTH < 2 || QUEUE_DEPTH > 128) begin : g_depth_check
    $error("queue depth must lie between 2 and 128");
  end

  localparam int CNT_W = $clog2(QUEUE_DEPTH) + 1;

  ////////////////////////////////////////////////////////////////////////////
  // State

  conv_state_t convState_r;
  conv_state_t convState_nxt;
  logic [7:0] status_r;
  logic [7:0] irqEnable_r;
  logic [15:0] highThreshold_r;
  logic [15:0] lowThreshold_r;
  logic [7:0] pinSetup_r;
  logic [7:0] pinOutput_r;
  logic alarmFlag_r;
  logic pinOnePrev_r;
  logic queueLowerNext_r;

  logic [1:0] pinZeroFunction;
  logic [1:0] pinOneFunction;
  logic [1:0] pinTwoFunction;
  logic cmdTrigger;
  logic pinTrigger;
  logic trigger;
  logic resultValid;
  logic belowLow;
  logic aboveHigh;
  logic statusRead;
  logic queueRead;
  logic [7:0] newEvents;
  logic [7:0] readMux;

  result_queue_if #(.WIDTH(RESULT_W), .CNT_W(CNT_W)) rq ();

  function automatic logic [7:0] pick_byte(input logic [15:0] word,
                                           input logic upper);
    pick_byte = upper ? word[15:8] : word[7:0];
  endfunction : pick_byte

  function automatic logic reg_hit(input logic strobe,
                                   input logic [7:0] addr,
                                   input logic [7:0] ofs);
    reg_hit = strobe && (addr == ofs);
  endfunction : reg_hit

  function automatic logic signed_less(input logic [15:0] a,
                                       input logic [15:0] b);
    signed_less = $signed(a) < $signed(b);
  endfunction : signed_less

  assign pinZeroFunction = pinSetup_r[POS_PIN_ZERO_FUNCTION +: 2];
  assign pinOneFunction = pinSetup_r[POS_PIN_ONE_FUNCTION +: 2];
  assign pinTwoFunction = pinSetup_r[POS_PIN_TWO_FUNCTION +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Conversion triggers and sequencing

  assign cmdTrigger = funcCmdValid && (funcCmdCode == CMD_CONVERT); // RULE_02
  assign pinTrigger = (pinOneFunction == PIN_SPECIAL) && pinIn[1]
                      && !pinOnePrev_r; // RULE_03
  assign trigger = cmdTrigger || pinTrigger;

  // Level of pin one last cycle, for its rising edge
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pinOnePrev_r <= 1'b0;
    end else begin
      pinOnePrev_r <= pinIn[1];
    end
  end

  always_comb begin
    convState_nxt = convState_r;
    unique case (convState_r)
      CONV_STANDBY: begin
        if (trigger) begin
          convState_nxt = CONV_START; // RULE_01
        end
      end
      CONV_START: begin
        // Triggers here and in CONV_WAIT are dropped
        convState_nxt = CONV_WAIT; // RULE_20
      end
      CONV_WAIT: begin
        if (sensorDone) begin
          convState_nxt = CONV_STANDBY; // RULE_05
        end
      end
      default: convState_nxt = CONV_STANDBY;
    endcase
  end

  // Triggers outside standby are simply not looked at
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      convState_r <= CONV_STANDBY; // RULE_01
    end else begin
      convState_r <= convState_nxt; // RULE_20
    end
  end

  assign sensorStart = (convState_r == CONV_START);
  // Master keeps the strong pullup on while this is high
  assign convBusy = (convState_r != CONV_STANDBY); // RULE_04
  assign resultValid = (convState_r == CONV_WAIT) && sensorDone;

  ////////////////////////////////////////////////////////////////////////////
  // Result queue

  assign rq.push = resultValid; // RULE_05
  assign rq.pushData = sensorResult; // RULE_07

  result_queue #(.WIDTH(RESULT_W), .DEPTH(QUEUE_DEPTH)) u_queue (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .q(rq.owner)
  ); // RULE_06

  assign queueRead = reg_hit(regRd, regAddr, OFS_QUEUE_DATA);
  // Upper byte first; the lower-byte read retires the entry
  assign rq.pop = queueRead && queueLowerNext_r && !rq.empty;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      queueLowerNext_r <= 1'b0;
    end else if (queueRead && !rq.empty) begin
      queueLowerNext_r <= !queueLowerNext_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Threshold compare and status

  assign belowLow = signed_less(sensorResult, lowThreshold_r); // RULE_08
  assign aboveHigh = signed_less(highThreshold_r, sensorResult); // RULE_08

  always_comb begin
    newEvents = 8'h00;
    if (resultValid) begin
      newEvents[BIT_BELOW_LOW] = belowLow; // RULE_10
      newEvents[BIT_ABOVE_HIGH] = aboveHigh; // RULE_10
      newEvents[BIT_QUEUE_OVERFLOW] = rq.full;
    end
  end

  assign statusRead = reg_hit(regRd, regAddr, OFS_STATUS);

  // New events win over a clearing read in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      status_r <= RST_STATUS;
    end else if (statusRead) begin
      status_r <= newEvents; // RULE_13
    end else begin
      status_r <= status_r | newEvents;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      alarmFlag_r <= 1'b0;
    end else if (|(newEvents & irqEnable_r)) begin
      alarmFlag_r <= 1'b1; // RULE_11
    end else if (statusRead) begin
      alarmFlag_r <= 1'b0; // RULE_13 RULE_14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm search

  assign alarmSearchJoin = alarmFlag_r; // RULE_16

  ////////////////////////////////////////////////////////////////////////////
  // Register writes

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      irqEnable_r <= RST_IRQ_ENABLE;
    end else if (reg_hit(regWr, regAddr, OFS_IRQ_ENABLE)) begin
      irqEnable_r <= regWrData; // RULE_11
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pinSetup_r <= RST_PIN_SETUP;
    end else if (reg_hit(regWr, regAddr, OFS_PIN_SETUP)) begin
      pinSetup_r <= regWrData; // RULE_19
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pinOutput_r <= RST_PIN_OUTPUT;
    end else if (reg_hit(regWr, regAddr, OFS_PIN_OUTPUT)) begin
      pinOutput_r <= regWrData;
    end
  end

  // Each byte lands alone; a torn pair is visible until both are written
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      highThreshold_r <= RST_HIGH_THRESHOLD; // RULE_15
    end else if (reg_hit(regWr, regAddr, OFS_HIGH_UPPER)) begin
      highThreshold_r[15:8] <= regWrData; // RULE_09
    end else if (reg_hit(regWr, regAddr, OFS_HIGH_LOWER)) begin
      highThreshold_r[7:0] <= regWrData; // RULE_09
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lowThreshold_r <= RST_LOW_THRESHOLD; // RULE_15
    end else if (reg_hit(regWr, regAddr, OFS_LOW_UPPER)) begin
      lowThreshold_r[15:8] <= regWrData; // RULE_09
    end else if (reg_hit(regWr, regAddr, OFS_LOW_LOWER)) begin
      lowThreshold_r[7:0] <= regWrData; // RULE_09
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads

  always_comb begin
    readMux = 8'h00;
    unique case (regAddr)
      OFS_STATUS: readMux = status_r;
      OFS_IRQ_ENABLE: readMux = irqEnable_r;
      OFS_QUEUE_COUNT: readMux = 8'(rq.count);
      OFS_QUEUE_DATA:
        readMux = rq.empty ? 8'h00
                  : pick_byte(rq.headData, !queueLowerNext_r);
      OFS_HIGH_UPPER: readMux = pick_byte(highThreshold_r, 1'b1);
      OFS_HIGH_LOWER: readMux = pick_byte(highThreshold_r, 1'b0);
      OFS_LOW_UPPER: readMux = pick_byte(lowThreshold_r, 1'b1);
      OFS_LOW_LOWER: readMux = pick_byte(lowThreshold_r, 1'b0);
      OFS_PIN_SETUP: readMux = pinSetup_r;
      OFS_PIN_OUTPUT: readMux = pinOutput_r;
      OFS_PIN_LEVEL: readMux = {5'h00, pinIn}; // RULE_18
      default: readMux = 8'h00;
    endcase
  end

  // Held between reads so the master may sample it late
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      regRdData <= 8'h00;
    end else if (regRd) begin
      regRdData <= readMux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins

  logic [1:0] pinFunc [3];
  logic [2:0] pinSpecialLow;

  assign pinFunc[0] = pinZeroFunction;
  assign pinFunc[1] = pinOneFunction;
  assign pinFunc[2] = pinTwoFunction;
  // Only pin zero drives in its special function; the others listen
  assign pinSpecialLow = {2'b00, alarmFlag_r}; // RULE_12

  for (genvar i = 0; i < 3; i++) begin : g_pin
    pin_cell u_pin (
      .func(pinFunc[i]),
      .outLevel(pinOutput_r[i]),
      .specialDriveLow(pinSpecialLow[i]),
      .padOut(pinOut[i]),
      .padOe(pinOe[i]),
      .pulldownEn(pinPulldown[i])
    ); // RULE_19
  end

endmodule : temp_conversion_alarm_core
`default_nettype wire

// ===== src/temp_alarm_pkg.sv
package temp_alarm_pkg;

  // Register offsets
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h01;
  localparam logic [7:0] OFS_QUEUE_COUNT = 8'h07;
  localparam logic [7:0] OFS_QUEUE_DATA = 8'h08;
  localparam logic [7:0] OFS_HIGH_UPPER = 8'h10;
  localparam logic [7:0] OFS_HIGH_LOWER = 8'h11;
  localparam logic [7:0] OFS_LOW_UPPER = 8'h12;
  localparam logic [7:0] OFS_LOW_LOWER = 8'h13;
  localparam logic [7:0] OFS_PIN_SETUP = 8'h20;
  localparam logic [7:0] OFS_PIN_OUTPUT = 8'h21;
  localparam logic [7:0] OFS_PIN_LEVEL = 8'h22;

  // Status and enable bit positions
  localparam int BIT_BELOW_LOW = 0;
  localparam int BIT_ABOVE_HIGH = 1;
  localparam int BIT_QUEUE_OVERFLOW = 2;

  // Pin setup field positions (two bits each)
  localparam int POS_PIN_ZERO_FUNCTION = 0;
  localparam int POS_PIN_ONE_FUNCTION = 2;
  localparam int POS_PIN_TWO_FUNCTION = 4;

  // Reset values
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_IRQ_ENABLE = 8'h00;
  localparam logic [15:0] RST_HIGH_THRESHOLD = 16'h7fff;
  localparam logic [15:0] RST_LOW_THRESHOLD = 16'h8000;
  localparam logic [7:0] RST_PIN_SETUP = 8'h2a;
  localparam logic [7:0] RST_PIN_OUTPUT = 8'h07;

  // Function command codes
  localparam logic [7:0] CMD_CONVERT = 8'h44;

  // Pin function codes
  localparam logic [1:0] PIN_HIZ_INPUT = 2'h0;
  localparam logic [1:0] PIN_OPEN_DRAIN = 2'h1;
  localparam logic [1:0] PIN_PULLDOWN_INPUT = 2'h2;
  localparam logic [1:0] PIN_SPECIAL = 2'h3;

  typedef enum logic [2:0] {
    CONV_STANDBY = 3'h1,
    CONV_START = 3'h2,
    CONV_WAIT = 3'h4
  } conv_state_t;

endpackage : temp_alarm_pkg

// ===== src/result_queue_if.sv
`timescale 1ns/1ps
`default_nettype none
interface result_queue_if #(
  parameter int WIDTH = 16,
  parameter int CNT_W = 6
);
  logic push;
  logic [WIDTH-1:0] pushData;
  logic pop;
  logic [WIDTH-1:0] headData;
  logic [CNT_W-1:0] count;
  logic full;
  logic empty;
  modport owner (input push, input pushData, input pop,
                 output headData, output count, output full, output empty);
  modport user (output push, output pushData, output pop,
                input headData, input count, input full, input empty);
endinterface : result_queue_if
`default_nettype wire

// ===== src/result_queue.sv
`timescale 1ns/1ps
`default_nettype none
module result_queue #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  result_queue_if.owner q
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
    $error("result_queue depth must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] rdPtr_r;
  logic [AW:0] count_r;
  logic doPush;
  logic doPop;

  assign doPush = q.push && !q.full;
  assign doPop = q.pop && !q.empty;
  assign q.full = (count_r == (AW+1)'(DEPTH));
  assign q.empty = (count_r == '0);
  assign q.headData = mem[rdPtr_r];
  assign q.count = ($bits(q.count))'(count_r);

  always_ff @(posedge sys_clk) begin
    if (doPush) begin
      mem[wrPtr_r] <= q.pushData;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_r + AW'(doPush);
      rdPtr_r <= rdPtr_r + AW'(doPop);
      count_r <= count_r + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end
endmodule : result_queue
`default_nettype wire

// ===== src/pin_cell.sv
`timescale 1ns/1ps
`default_nettype none
module pin_cell
  import temp_alarm_pkg::*;
(
  input wire logic [1:0] func,
  input wire logic outLevel,
  input wire logic specialDriveLow,
  output logic padOut,
  output logic padOe,
  output logic pulldownEn
);
  // Open-drain: only ever drives low
  assign padOut = 1'b0;
  always_comb begin
    padOe = 1'b0;
    pulldownEn = 1'b0;
    unique case (func)
      PIN_HIZ_INPUT: padOe = 1'b0;
      PIN_OPEN_DRAIN: padOe = !outLevel;
      PIN_PULLDOWN_INPUT: pulldownEn = 1'b1;
      PIN_SPECIAL: padOe = specialDriveLow;
    endcase
  end
endmodule : pin_cell
`default_nettype wire

// ===== sim/sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module sensor_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] delay,
  input wire logic [15:0] value,
  output logic done,
  output logic [15:0] result
);
  logic [7:0] cnt;
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt <= 8'h0;
      done <= 1'b0;
      result <= 16'h0;
    end else begin
      done <= 1'b0;
      // Released result lines toggle so stale data never matches
      result <= ~result;
      if (start) begin
        cnt <= delay;
      end else if (cnt != 8'h0) begin
        cnt <= cnt - 8'h1;
        if (cnt == 8'h1) begin
          done <= 1'b1;
          result <= value;
        end
      end
    end
  end
endmodule : sensor_model
`default_nettype wire

// ===== sim/temp_conversion_alarm_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module temp_conversion_alarm_core_assertions #(
  parameter int RESULT_W = 16,
  parameter int QUEUE_DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic funcCmdValid,
  input wire logic [7:0] funcCmdCode,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic sensorStart,
  input wire logic sensorDone,
  input wire logic [RESULT_W-1:0] sensorResult,
  input wire logic convBusy,
  input wire logic alarmSearchJoin,
  input wire logic [2:0] pinIn,
  input wire logic [2:0] pinOut,
  input wire logic [2:0] pinOe,
  input wire logic [2:0] pinPulldown
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic stRd;
  logic fin;
  assign stRd = regRd && regAddr == 8'h00;
  assign fin = convBusy && !sensorStart && sensorDone;
  property p_cmd;
    !convBusy && funcCmdValid && funcCmdCode == 8'h44
      |=> sensorStart && convBusy;
  endproperty
  a_cmd: assert property (p_cmd) else $error("no start");
  property p_pulse;
    sensorStart |-> convBusy ##1 !sensorStart;
  endproperty
  a_pulse: assert property (p_pulse) else $error("start len");
  property p_idle;
    !convBusy && !funcCmdValid && !pinIn[1] |=> !sensorStart;
  endproperty
  a_idle: assert property (p_idle) else $error("stray start");
  property p_busy;
    convBusy && !sensorDone |=> convBusy && !sensorStart;
  endproperty
  a_busy: assert property (p_busy) else $error("restart");
  property p_done;
    fin |=> !convBusy;
  endproperty
  a_done: assert property (p_done) else $error("busy stuck");
  property p_sticky;
    alarmSearchJoin && !stRd |=> alarmSearchJoin;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_clear;
    stRd && !fin |=> !alarmSearchJoin;
  endproperty
  a_clear: assert property (p_clear) else $error("flag kept");
  property p_rise;
    $rose(alarmSearchJoin) |-> $past(fin);
  endproperty
  a_rise: assert property (p_rise) else $error("flag cause");
  property p_drive;
    pinOut == 3'h0 && (pinOe & pinPulldown) == 3'h0;
  endproperty
  a_drive: assert property (p_drive) else $error("pin drive");
  c_conv: cover property (fin);
  c_flag: cover property ($rose(alarmSearchJoin));
  c_clear: cover property (stRd && alarmSearchJoin);
endmodule : temp_conversion_alarm_core_assertions
bind temp_conversion_alarm_core temp_conversion_alarm_core_assertions #(
  .RESULT_W(RESULT_W),
  .QUEUE_DEPTH(QUEUE_DEPTH)
) chk_i (
  .sys_clk(sys_clk),
  .rst_n(rst_n),
  .funcCmdValid(funcCmdValid),
  .funcCmdCode(funcCmdCode),
  .regWr(regWr),
  .regRd(regRd),
  .regAddr(regAddr),
  .regWrData(regWrData),
  .regRdData(regRdData),
  .sensorStart(sensorStart),
  .sensorDone(sensorDone),
  .sensorResult(sensorResult),
  .convBusy(convBusy),
  .alarmSearchJoin(alarmSearchJoin),
  .pinIn(pinIn),
  .pinOut(pinOut),
  .pinOe(pinOe),
  .pinPulldown(pinPulldown)
);
`default_nettype wire

// ===== sim/temp_conversion_alarm_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
module temp_conversion_alarm_core_bench;
  import temp_alarm_pkg::*;
  logic sys_clk = 0, rst_n = 0, funcCmdValid = 0, regWr = 0, regRd = 0;
  logic [7:0] funcCmdCode = 0, regAddr = 0, regWrData = 0, regRdData, rd;
  logic sensorStart, sensorDone, convBusy, alarmSearchJoin;
  logic [15:0] sensorResult, res = 0;
  logic [7:0] dly = 8'h3;
  logic [2:0] pinDrv = 0, pinIn, pinOut, pinOe, pinPulldown;
  int failures = 0, samples_checked = 0, starts = 0, qn = 0;
  assign pinIn = pinDrv & ~pinOe;
  temp_conversion_alarm_core uut (.*);
  sensor_model sm (.sys_clk, .rst_n, .start(sensorStart), .delay(dly),
    .value(res), .done(sensorDone), .result(sensorResult));
  initial forever #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (sensorStart) starts++;
  ////////////////
  task tick;
    @(posedge sys_clk);
    #1;
  endtask : tick
  task chk(input logic [7:0] s, input logic [7:0] e);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task final_report;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWr = 1;
    tick;
    regWr = 0;
    tick;
  endtask : wr
  task rdr(input logic [7:0] a);
    regAddr = a;
    regRd = 1;
    tick;
    rd = regRdData;
    regRd = 0;
    tick;
  endtask : rdr
  task wrth(input logic [15:0] h, input logic [15:0] l);
    wr(OFS_HIGH_UPPER, h[15:8]);
    wr(OFS_HIGH_LOWER, h[7:0]);
    wr(OFS_LOW_UPPER, l[15:8]);
    wr(OFS_LOW_LOWER, l[7:0]);
  endtask : wrth
  task conv(input logic [15:0] r, input bit pin, pop, extra);
    int n, s0;
    logic [7:0] hi;
    res = r;
    s0 = starts;
    if (pin) pinDrv[1] = 1;
    else funcCmdValid = 1;
    funcCmdCode = CMD_CONVERT;
    tick;
    funcCmdValid = extra;
    chk(8'(convBusy), 8'h1);
    tick;
    funcCmdValid = 0;
    n = 0;
    while (convBusy && n < 200) begin
      tick;
      n++;
    end
    if (convBusy) begin
      failures++;
      final_report;
    end
    pinDrv[1] = 0;
    chk(8'(starts - s0), 8'h1);
    if (pop) begin
      rdr(OFS_QUEUE_DATA);
      hi = rd;
      rdr(OFS_QUEUE_DATA);
      chk(hi, r[15:8]);
      chk(rd, r[7:0]);
    end else qn++;
  endtask : conv
  function automatic logic [7:0] st(logic [15:0] r, hh, ll);
    return {6'h0, $signed(r) > $signed(hh), $signed(r) < $signed(ll)};
  endfunction : st
  ////////////////
  initial begin
    logic [15:0] r, h, l;
    logic [7:0] e, en;
    int s;
    static logic [7:0] ra[11] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h20, 8'h30,
      8'h00, 8'h01, 8'h07, 8'h08, 8'h21};
    static logic [7:0] rv[11] = '{8'h7f, 8'hff, 8'h80, 8'h00, 8'h2a, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h07};
    void'($urandom(32'h3c30ac35));
    repeat (8) @(posedge sys_clk);
    #1 rst_n = 1;
    chk(8'(pinPulldown), 8'h7);
    for (int k = 0; k < 11; k++) begin
      rdr(ra[k]);
      chk(rd, rv[k]);
    end
    funcCmdCode = 8'h45;
    funcCmdValid = 1;
    tick;
    funcCmdValid = 0;
    repeat (20) tick;
    chk(8'(starts), 8'h0);
    $display("test reset done");
    h = 16'($urandom);
    l = 16'($urandom);
    wrth(h, l);
    rdr(OFS_HIGH_LOWER);
    chk(rd, h[7:0]);
    rdr(OFS_LOW_UPPER);
    chk(rd, l[15:8]);
    wr(OFS_PIN_SETUP, 8'h2b);
    for (int i = 0; i < 12; i++) begin
      r = i == 0 ? h : i == 1 ? h + 1 : i == 2 ? l : i == 3 ? l - 1
        : 16'($urandom);
      en = i[0] ? 8'h01 : 8'h03;
      wr(OFS_IRQ_ENABLE, en);
      conv(r, 0, 1, 0);
      e = st(r, h, l);
      chk(8'(alarmSearchJoin), 8'((e & en) != 0));
      chk(8'(pinOe[0]), 8'((e & en) != 0));
      rdr(OFS_STATUS);
      chk(rd, e);
      chk(8'(alarmSearchJoin), 8'h0);
      chk(8'(pinOe[0]), 8'h0);
    end
    $display("test alarm done");
    wrth(16'h2710, 16'h0bb8);
    wr(OFS_IRQ_ENABLE, 8'h03);
    rdr(OFS_STATUS);
    dly = 8'd20;
    conv(16'h36b0, 0, 0, 0);
    conv(16'h1388, 0, 0, 1);
    dly = 8'h3;
    chk(8'(alarmSearchJoin), 8'h1);
    rdr(OFS_STATUS);
    chk(rd, 8'h02);
    $display("test sticky done");
    wr(OFS_PIN_SETUP, 8'h2f);
    conv(16'h1388, 1, 0, 0);
    wr(OFS_PIN_SETUP, 8'h2b);
    s = starts;
    pinDrv[1] = 1;
    repeat (4) tick;
    pinDrv[1] = 0;
    chk(8'(starts - s), 8'h0);
    $display("test pin trigger done");
    wr(OFS_PIN_SETUP, 8'h00);
    chk(8'(pinPulldown), 8'h0);
    for (int k = 0; k < 8; k++) begin
      pinDrv = k[2:0];
      repeat (3) tick;
      rdr(OFS_PIN_LEVEL);
      chk(rd, 8'(k));
    end
    wr(OFS_PIN_SETUP, 8'h15);
    wr(OFS_PIN_OUTPUT, 8'h00);
    chk(8'(pinOe), 8'h7);
    wr(OFS_PIN_OUTPUT, 8'h07);
    chk(8'(pinOe), 8'h0);
    rdr(OFS_PIN_OUTPUT);
    chk(rd, 8'h07);
    $display("test pins done");
    wrth(16'h7fff, 16'h8000);
    while (qn < 33) conv(16'h0, 0, 0, 0);
    rdr(OFS_QUEUE_COUNT);
    chk(rd, 8'h20);
    rdr(OFS_STATUS);
    chk(rd, 8'h04);
    $display("test queue done");
    final_report;
  end
endmodule : temp_conversion_alarm_core_bench
`default_nettype wire
